/* File: common/ipr_pkg.sv */
// Constants for the priority register seven block.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package ipr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  REG_PRIO_ADDR   = 4'h0;     // irq_priority_seven offset
  localparam logic [3:0]  REG_LEVELS_ADDR = 4'h4;     // Live decoded level status
  localparam logic [15:0] PRIO_RESET      = 16'h4444; // Reset value of the register
  localparam logic [15:0] PRIO_WMASK      = 16'h7777; // Implemented bits
  localparam logic [2:0]  LEVEL_OFF       = 3'h0;     // Source disabled
  localparam logic [2:0]  LEVEL_LOW       = 3'h1;     // Lowest enabled level
  localparam logic [2:0]  LEVEL_HIGH      = 3'h7;     // Highest level
  // Field bases: timer5, ext irq2, serial rx, serial tx
  localparam int          FIELD_W         = 4;        // Nibble pitch per field
  localparam int          NUM_FIELDS      = 4;        // Fields in the register
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0;    // Read data of unmapped word
endpackage

/* File: rtl/ipr_field.sv */
// One 3-bit priority field with its enable decode.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/100ps
module ipr_field (
  input  wire logic       sys_clk,   // System clock
  input  wire logic       rst,       // Synchronous reset, active high
  input  wire logic       wrEn,      // Write this field
  input  wire logic [2:0] wrData,    // New level
  output logic      [2:0] level,     // Stored level
  output logic            enabled    // Source may request
);
  logic [2:0] next_level; // Next stored level
  logic       next_enabled; // Next enable flag

  // Next value: reset loads level 4, write replaces it
  always_comb begin
    next_level = level;
    if (rst) begin
      next_level = ipr_pkg::PRIO_RESET[2:0]; // R7
    end else if (wrEn) begin
      next_level = wrData;
    end
    // Zero disables the source, 1..7 enable it
    next_enabled = (next_level != ipr_pkg::LEVEL_OFF); // R6
  end

  // Register the field
  always_ff @(posedge sys_clk) begin
    level   <= next_level;
    enabled <= next_enabled;
  end
endmodule // ipr_field

/* File: rtl/ipr_priority_reg.sv */
// Priority register seven on a classic Wishbone slave.
// Assumes a single-clock Wishbone master; outputs feed arbitration logic.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/100ps
// Overview of operation
// R1: Bits 15, 11, 7, 3 read zero
// R2: Serial tx priority at bits 14..12
// R3: Serial rx priority at bits 10..8
// R4: Value 111 means level seven, highest
// R5: Value 001 means level one, lowest
// R6: Value 000 disables the source
// R7: Reset loads 0x4444
// R8: Ext irq2 bits 6..4, timer5 bits 2..0
module ipr_priority_reg (
  input  wire logic        sys_clk,            // System clock
  input  wire logic        rst,                // Synchronous reset
  input  wire logic        wb_cyc_i,           // Bus cycle
  input  wire logic        wb_stb_i,           // Strobe
  input  wire logic        wb_we_i,            // Write enable
  input  wire logic [3:0]  wb_adr_i,           // Byte address
  input  wire logic [3:0]  wb_sel_i,           // Byte selects
  input  wire logic [31:0] wb_dat_i,           // Write data
  output logic      [31:0] wb_dat_o,           // Read data
  output logic             wb_ack_o,           // Acknowledge
  output logic      [2:0]  serial2_tx_priority, // Serial tx level
  output logic      [2:0]  serial2_rx_priority, // Serial rx level
  output logic      [2:0]  ext_irq2_priority,   // Ext irq2 level
  output logic      [2:0]  timer5_priority,     // Timer5 level
  output logic      [3:0]  srcEnabled          // Per-source enable, tx..timer5
);
  // ****************************************
  // Map and timing notes
  // ****************************************
  // Word 0x0 holds the four priority fields, one per nibble:
  //   nibble 3 serial tx, nibble 2 serial rx,
  //   nibble 1 external irq 2, nibble 0 timer5.
  // The top bit of every nibble is not built; it reads zero and
  // a write to it is dropped without any side effect.
  // Word 0x4 is a read-only status view of the same fields:
  //   bit 0 of a nibble says the source is enabled,
  //   bit 1 says the source sits at the highest level.
  // A write to word 0x4 is acknowledged and thrown away.
  // Any other address acknowledges and reads zero, so a stray
  // access never hangs the bus.
  //
  // Bus timing:
  //   edge 1 takes the request (cyc, stb high, ack low),
  //          writes the selected fields and loads read data;
  //   edge 2 shows ack to the master, which then releases;
  //          ack drops here, because req masks itself with ack.
  // Every access therefore costs two edges; no wait states
  // beyond that are ever inserted.
  //
  // Byte lanes:
  //   sel[0] covers timer5 and external irq 2,
  //   sel[1] covers serial rx and serial tx,
  //   sel[3:2] reach no storage at all.
  // A partial-word write leaves the other lane untouched, so
  // software may change one byte without a read-modify-write.
  //
  // Level outputs change on the same edge that takes the write (edge 1) and
  // hold until the next write or reset. The arbiter downstream
  // sees the new level and the new enable in the same cycle,
  // which avoids a one-cycle window of an enabled source at an
  // old level.
  //
  // Limitation: the register has no write lock. Software that
  // changes a level while that source is pending must accept
  // that the arbiter uses the new level from the next cycle.

  // ****************************************
  // Bus decode
  // ****************************************
  logic        req;        // New request, not yet acknowledged
  logic        next_ack;   // Next ack
  logic [31:0] next_dat;   // Next read data
  logic [15:0] irqPrioritySeven; // Assembled register view
  logic [3:0]  fieldWr;    // Per-field write strobe
  logic [2:0]  levels [4]; // Stored levels, index 0 is timer5
  logic [3:0]  enBits;     // Enable flags from fields
  logic [15:0] levelStatus; // One nibble per field: enabled flag and max flag

  // Ack drops the cycle after it was given, so each access takes two edges
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ****************************************
  // Field storage
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < ipr_pkg::NUM_FIELDS; g++) begin : gField
      // Field g sits in byte g/2; writes need that byte lane selected
      assign fieldWr[g] = req & wb_we_i & (wb_adr_i == ipr_pkg::REG_PRIO_ADDR)
                          & wb_sel_i[g/2]; // R2 R3 R8
      ipr_field uField (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wrEn    (fieldWr[g]),
        .wrData  (wb_dat_i[g*ipr_pkg::FIELD_W +: 3]),
        .level   (levels[g]),
        .enabled (enBits[g])
      );
      // Unimplemented top bit of each nibble stays zero
      assign irqPrioritySeven[g*ipr_pkg::FIELD_W +: 4] = {1'b0, levels[g]}; // R1
      assign levelStatus[g*ipr_pkg::FIELD_W +: 4] =
        {2'h0, levels[g] == ipr_pkg::LEVEL_HIGH, enBits[g]}; // R4 R5
    end
  endgenerate

  // Read mux and ack; unmapped words read zero and still ack
  always_comb begin
    next_ack = rst ? 1'b0 : req;
    next_dat = ipr_pkg::UNMAPPED_DATA;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ipr_pkg::REG_PRIO_ADDR:   next_dat = {16'h0, irqPrioritySeven}; // R1
        ipr_pkg::REG_LEVELS_ADDR: next_dat = {16'h0, levelStatus};
        default:                  next_dat = ipr_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // Register bus answers: ack and read data
  always_ff @(posedge sys_clk) begin
    wb_ack_o <= next_ack;
    wb_dat_o <= next_dat;
  end

  // Outputs are the field flops themselves
  assign serial2_tx_priority = levels[3]; // R2
  assign serial2_rx_priority = levels[2]; // R3
  assign ext_irq2_priority   = levels[1]; // R8
  assign timer5_priority     = levels[0]; // R8
  assign srcEnabled          = enBits;    // R6

  // ****************************************
  // Checks
  // ****************************************
  resetVal_a: assert property (@(posedge sys_clk) rst |=> irqPrioritySeven == ipr_pkg::PRIO_RESET)
    else $error("reset value wrong"); // R7
  unimpl_a: assert property (@(posedge sys_clk) (irqPrioritySeven & ~ipr_pkg::PRIO_WMASK) == 16'h0)
    else $error("unimplemented bit set"); // R1
  txWrite_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[3] |=> serial2_tx_priority == $past(wb_dat_i[14:12]))
    else $error("tx field not written"); // R2
  rxWrite_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[2] |=> serial2_rx_priority == $past(wb_dat_i[10:8]))
    else $error("rx field not written"); // R3
  extWrite_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[1] |=> ext_irq2_priority == $past(wb_dat_i[6:4]))
    else $error("ext field not written"); // R8
  disable_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[0] && wb_dat_i[2:0] == ipr_pkg::LEVEL_OFF |=> !srcEnabled[0])
    else $error("zero level enabled"); // R6
  lowLevel_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[0] && wb_dat_i[2:0] == ipr_pkg::LEVEL_LOW |=> srcEnabled[0] && !levelStatus[1])
    else $error("level one wrong"); // R5
  highLevel_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[1] && wb_dat_i[6:4] == ipr_pkg::LEVEL_HIGH |=> levelStatus[5] && srcEnabled[1])
    else $error("level seven wrong"); // R4
  ackOnce_a: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // ****************************************
  // Field and bus checks
  // ****************************************
  // Timer5 takes its write one edge later, like the other three
  tmrWrite_a: assert property (@(posedge sys_clk) disable iff (rst)
    fieldWr[0] |=> timer5_priority == $past(wb_dat_i[2:0]))
    else $error("timer5 field not written"); // R8

  // Without a field write the whole register holds its value
  holdLevels_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(|fieldWr) |=> $stable(irqPrioritySeven))
    else $error("register changed without write"); // R2

  // High lane off: serial fields must not move
  highLane_a: assert property (@(posedge sys_clk) disable iff (rst)
    req && wb_we_i && !wb_sel_i[1] |=> $stable(serial2_tx_priority)
    && $stable(serial2_rx_priority))
    else $error("serial field written without lane"); // R3

  // Low lane off: timer5 and ext irq2 must not move
  lowLane_a: assert property (@(posedge sys_clk) disable iff (rst)
    req && wb_we_i && !wb_sel_i[0] |=> $stable(timer5_priority)
    && $stable(ext_irq2_priority))
    else $error("low field written without lane"); // R8

  // Each enable flag follows its own level, never a stale one
  enTx_a: assert property (@(posedge sys_clk) disable iff (rst)
    srcEnabled[3] == (serial2_tx_priority != ipr_pkg::LEVEL_OFF))
    else $error("tx enable mismatch"); // R6

  enRx_a: assert property (@(posedge sys_clk) disable iff (rst)
    srcEnabled[2] == (serial2_rx_priority != ipr_pkg::LEVEL_OFF))
    else $error("rx enable mismatch"); // R6

  enExt_a: assert property (@(posedge sys_clk) disable iff (rst)
    srcEnabled[1] == (ext_irq2_priority != ipr_pkg::LEVEL_OFF))
    else $error("ext enable mismatch"); // R6

  enTmr_a: assert property (@(posedge sys_clk) disable iff (rst)
    srcEnabled[0] == (timer5_priority != ipr_pkg::LEVEL_OFF))
    else $error("timer5 enable mismatch"); // R6

  // Highest-level flag in the status view, one per field
  maxTx_a: assert property (@(posedge sys_clk) disable iff (rst)
    levelStatus[13] == (serial2_tx_priority == ipr_pkg::LEVEL_HIGH))
    else $error("tx max flag wrong"); // R4

  maxRx_a: assert property (@(posedge sys_clk) disable iff (rst)
    levelStatus[9] == (serial2_rx_priority == ipr_pkg::LEVEL_HIGH))
    else $error("rx max flag wrong"); // R4

  maxExt_a: assert property (@(posedge sys_clk) disable iff (rst)
    levelStatus[5] == (ext_irq2_priority == ipr_pkg::LEVEL_HIGH))
    else $error("ext max flag wrong"); // R4

  maxTmr_a: assert property (@(posedge sys_clk) disable iff (rst)
    levelStatus[1] == (timer5_priority == ipr_pkg::LEVEL_HIGH))
    else $error("timer5 max flag wrong"); // R4

  // A read of word 0 returns the register as it stood when taken
  readPrio_a: assert property (@(posedge sys_clk) disable iff (rst)
    req && !wb_we_i && wb_adr_i == ipr_pkg::REG_PRIO_ADDR
    |=> wb_dat_o == {16'h0, $past(irqPrioritySeven)})
    else $error("register read data wrong"); // R1

  // A read of the status word returns the live flags
  readStatus_a: assert property (@(posedge sys_clk) disable iff (rst)
    req && !wb_we_i && wb_adr_i == ipr_pkg::REG_LEVELS_ADDR
    |=> wb_dat_o == {16'h0, $past(levelStatus)})
    else $error("status read data wrong");

  // Writes return zero data so nothing stale leaks onto the bus
  writeZero_a: assert property (@(posedge sys_clk) disable iff (rst)
    req && wb_we_i |=> wb_dat_o == ipr_pkg::UNMAPPED_DATA)
    else $error("write returned data");

  // Every taken request is answered on the very next edge
  ackFollows_a: assert property (@(posedge sys_clk) disable iff (rst)
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  // No ack without a request; a spurious ack would end a later cycle early
  ackIdle_a: assert property (@(posedge sys_clk) disable iff (rst)
    !req |=> !wb_ack_o)
    else $error("ack without request");

  // Reset clears the ack and enables every source at level 4
  resetAck_a: assert property (@(posedge sys_clk)
    rst |=> !wb_ack_o && (&srcEnabled))
    else $error("reset state wrong"); // R7
  cWrite_c: cover property (@(posedge sys_clk) fieldWr[3]);
  cRead_c: cover property (@(posedge sys_clk) wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
  cOff_c: cover property (@(posedge sys_clk) srcEnabled == 4'h0);
  // Status word read while some status flag is set, enabled or highest level
  cStatus_c: cover property (@(posedge sys_clk)
    req && !wb_we_i && wb_adr_i == ipr_pkg::REG_LEVELS_ADDR && (|levelStatus));
endmodule // ipr_priority_reg

/* File: testbench/test_interrupt_priority_reg_seven.sv */
// Self-checking bench for the priority register seven block.
// Assumes the design answers every Wishbone request and resets synchronously.
`timescale 1ns/100ps
module test_interrupt_priority_reg_seven;
  logic        sys_clk = 1'b0;  // 50 MHz clock
  logic        rst     = 1'b1;  // Synchronous reset
  logic        wbCyc   = 1'b0;  // Bus cycle
  logic        wbStb   = 1'b0;  // Strobe
  logic        wbWe    = 1'b0;  // Direction
  logic [3:0]  wbAdr   = 4'h0;  // Byte address
  logic [3:0]  wbSel   = 4'h0;  // Byte lanes
  logic [31:0] wbDatI  = 32'h0; // Write data
  logic [31:0] wbDatO;          // Read data
  logic        wbAck;           // Acknowledge
  logic [2:0]  txP, rxP, extP, tmrP; // Field levels
  logic [3:0]  srcEn;           // Source enables
  logic [31:0] rd;              // Last read value
  int          numErrors = 0;   // Mismatch count
  int          checks    = 0;   // Comparison count
  int          cycles    = 0;   // Watchdog count
  ipr_priority_reg dut_u (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .serial2_tx_priority(txP), .serial2_rx_priority(rxP),
    .ext_irq2_priority(extP), .timer5_priority(tmrP), .srcEnabled(srcEn));
  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  initial forever #10 sys_clk = ~sys_clk;
  // A hung handshake would stall forever, so cap the run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      numErrors++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Classic single cycle; read data is taken at the falling edge where ack is seen high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat);
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= sel;
    wbDatI <= dat;
    // Look between edges, where ack and read data have settled
    do @(negedge sys_clk); while (wbAck !== 1'b1);
    rd = wbDatO;
    @(posedge sys_clk);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  // Reset image, read back and on the level outputs
  task automatic t_reset();
    wb(1'b0, 4'h0, 4'h3, 32'h0);
    chk("reset value", rd, 32'h00004444);
    chk("reset levels", {txP, rxP, extP, tmrP, srcEn}, {3'h4, 3'h4, 3'h4, 3'h4, 4'hf});
  endtask
  // Distinct levels prove each field sits at its own bits
  task automatic t_fields();
    wb(1'b1, 4'h0, 4'h3, 32'h0000ffff);
    chk("all ones", {txP, rxP, extP, tmrP}, {4{3'h7}});
    wb(1'b0, 4'h0, 4'h3, 32'h0);
    chk("reserved bits", rd, 32'h00007777);
    wb(1'b0, 4'h4, 4'h3, 32'h0);
    chk("max flags", rd, 32'h00003333);
    wb(1'b1, 4'h0, 4'h3, 32'h00006352);
    chk("tx rx levels", {txP, rxP}, {3'h6, 3'h3});
    chk("ext tmr levels", {extP, tmrP}, {3'h5, 3'h2});
    wb(1'b1, 4'h0, 4'h3, 32'h00000101);
    chk("off and lowest", {txP, rxP, extP, tmrP}, {3'h0, 3'h1, 3'h0, 3'h1});
    chk("enables", srcEn, 32'h5);
    wb(1'b0, 4'h4, 4'h3, 32'h0);
    chk("status lowest", rd, 32'h00000101);
  endtask
  // Lane select, unmapped read and a reset in mid-run
  task automatic t_misc();
    wb(1'b1, 4'h0, 4'h1, 32'h0000ffff);
    wb(1'b1, 4'h4, 4'h3, 32'h0);
    wb(1'b0, 4'h0, 4'h3, 32'h0);
    chk("low lane only", rd, 32'h00000177);
    wb(1'b0, 4'h8, 4'h3, 32'h0);
    chk("unmapped", rd, 32'h0);
    do_reset();
    t_reset();
  endtask
  task automatic complete_run();
    if (numErrors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    do_reset();
    t_reset();
    t_fields();
    t_misc();
    complete_run();
  end
endmodule // test_interrupt_priority_reg_seven
